// *** hw/ris_sequencer.sv ***
// reset initialization sequencer: reset pins, strap capture, pll lock watch
//
// Overview of operation
// R1: external hard reset needs 32 sync periods
// R2: host mode power-on reset 32 clock periods
// R3: agent mode power-on reset 32 sync periods
// R4: driven hard reset lasts 512 sync periods
// R5: 16 sync periods between hard reset negations
// R6: straps valid 4 periods before release
// R7: straps: reset source, bus mux, divide
// R8: capture straps at power-on release, hold
// R9: release strap pins when hard reset asserts
// R10: wait a sync period before functional drive
// R11: host mode sync period from divide setting
// R12: pll lock within 100 microseconds
// R13: hard and soft reset open drain only
// R14: power-on reset is input only
`timescale 1ns/1ps
module ris_sequencer #(
  parameter int PllLockCycles = ris_pkg::PLL_LOCK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // reset pins
  input wire logic power_on_reset_n,
  input wire logic hardResetNIn,
  output logic hardResetNOut,
  output logic hardResetNOe,
  input wire logic softResetNIn,
  output logic softResetNOut,
  output logic softResetNOe,
  // reference clocks, mode and pll lock, as pins
  input wire logic primary_input_clock,
  input wire logic syncRefClock,
  input wire logic hostMode,
  input wire logic pllLocked,
  // shared strap pins
  input wire ris_pkg::ris_cfg_type strapIn,
  output ris_pkg::ris_cfg_type strapOut,
  output logic strapOe,
  // user side
  input wire ris_pkg::ris_cfg_type funcData,
  input wire logic hardResetReq,
  input wire logic softResetReq,
  output ris_pkg::ris_cfg_type cfgCaptured,
  output logic functionalEnable,
  output logic porTooShort,
  output logic pllLockError,
  output logic syncTick
);
  import ris_pkg::*;

  localparam logic [LOCK_W-1:0] LOCK_LIMIT = LOCK_W'(PllLockCycles);
  localparam logic [TICK_W-1:0] DRIVE_LAST = TICK_W'(DRIVE_MIN_PERIODS - 1);
  localparam logic [TICK_W-1:0] GAP_LAST = TICK_W'(NEGATE_GAP_PERIODS - 1);
  localparam logic [EXT_W-1:0] EXT_LIMIT = EXT_W'(EXT_MIN_PERIODS);

  // rising edge of a synchronised level
  function automatic logic riseOf(input logic now, input logic last);
    riseOf = now & ~last;
  endfunction

  // two-flop synchronisers for every pin input, edge history for the single-bit pins
  logic [6:0] pinMeta, pinSync, pinLast;
  ris_cfg_type strapMeta, strapSync;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pinMeta <= 7'h00; // pins read as asserted until really seen
      pinSync <= 7'h00;
      pinLast <= 7'h00;
      strapMeta <= CFG_RST;
      strapSync <= CFG_RST;
    end
    else
    begin
      pinMeta <= {pllLocked, hostMode, syncRefClock, primary_input_clock,
                  softResetNIn, hardResetNIn, power_on_reset_n};
      pinSync <= pinMeta;
      pinLast <= pinSync;
      strapMeta <= strapIn;
      strapSync <= strapMeta;
    end
  end

  logic porLow, hardLow, primRise, syncRise, hostSync, lockSync;
  assign porLow = ~pinSync[0];
  assign hardLow = ~pinSync[1];
  assign primRise = riseOf(pinSync[3], pinLast[3]);
  assign syncRise = riseOf(pinSync[4], pinLast[4]);
  assign hostSync = pinSync[5];
  assign lockSync = pinSync[6];

  // sync reference tick: agent mode uses its pin, host mode divides the primary clock
  logic divPhaseQ, divPhaseD, tickQ, tickD;
  logic divSel;
  always_comb
  begin
    divSel = cfgCaptured.inputClockDivide;
    divPhaseD = divPhaseQ;
    tickD = 1'b0;
    if (!hostSync)
      tickD = syncRise;
    // R11 divide setting applied
    else if (primRise)
    begin
      divPhaseD = divSel ? ~divPhaseQ : 1'b0;
      tickD = divSel ? divPhaseQ : 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      divPhaseQ <= 1'b0;
      tickQ <= 1'b0;
    end
    else
    begin
      divPhaseQ <= divPhaseD;
      tickQ <= tickD;
    end
  end
  assign syncTick = tickQ;

  // main sequencer state, counters and captured straps
  ris_state_type stateQ, stateD;
  logic [TICK_W-1:0] tickCntQ, tickCntD;
  logic [EXT_W-1:0] extCntQ, extCntD, porCntQ, porCntD;
  logic [LOCK_W-1:0] lockCntQ, lockCntD;
  logic lockErrQ, lockErrD, porShortQ, porShortD;
  ris_cfg_type cfgQ, cfgD, strapOutQ, strapOutD;
  logic porTick;

  always_comb
  begin
    stateD = stateQ;
    tickCntD = tickCntQ;
    extCntD = extCntQ;
    porCntD = porCntQ;
    lockCntD = lockCntQ;
    lockErrD = lockErrQ;
    porShortD = porShortQ;
    cfgD = cfgQ;
    strapOutD = funcData;
    // R2 host mode counts the primary clock, R3 agent mode the sync clock
    porTick = hostSync ? primRise : syncRise;
    // R1 measure an outside hard reset pulse
    if (!hardLow || stateQ != ST_RUN)
      extCntD = '0;
    else if (tickQ && extCntQ != EXT_LIMIT)
      extCntD = extCntQ + 1'b1;
    case (stateQ)
      ST_POR:
      begin
        tickCntD = '0;
        lockCntD = '0;
        if (porLow)
        begin
          if (porTick && porCntQ != EXT_LIMIT)
            porCntD = porCntQ + 1'b1;
        end
        else
        begin
          // R7 R8 capture strap set
          cfgD = strapSync;
          // R2 flag a power-on pulse that was too short
          porShortD = (porCntQ != EXT_LIMIT);
          lockErrD = 1'b0;
          stateD = ST_DRIVE;
        end
      end
      ST_DRIVE:
      begin
        // R12 pll lock watchdog
        if (!lockSync && lockCntQ != LOCK_LIMIT)
          lockCntD = lockCntQ + 1'b1;
        if (!lockSync && lockCntQ == LOCK_LIMIT - 1'b1)
          lockErrD = 1'b1;
        // R4 hold hard reset for the full count and until lock
        if (tickQ && tickCntQ != DRIVE_LAST)
          tickCntD = tickCntQ + 1'b1;
        else if (tickQ && lockSync)
        begin
          tickCntD = '0;
          stateD = ST_GAP;
        end
      end
      ST_GAP:
      begin
        // R5 spacing, R10 wait before functional drive
        if (hardLow)
          tickCntD = '0;
        else if (tickQ && tickCntQ != GAP_LAST)
          tickCntD = tickCntQ + 1'b1;
        else if (tickQ)
        begin
          tickCntD = '0;
          stateD = ST_RUN;
        end
      end
      ST_RUN:
      begin
        // R1 a long enough outside pulse restarts the flow
        if (hardResetReq || extCntQ == EXT_LIMIT)
        begin
          tickCntD = '0;
          stateD = ST_DRIVE;
        end
      end
      default:
        stateD = ST_POR;
    endcase
    if (porLow && stateQ != ST_POR)
    begin
      porCntD = '0;
      stateD = ST_POR;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      stateQ <= ST_POR;
      tickCntQ <= '0;
      extCntQ <= '0;
      porCntQ <= '0;
      lockCntQ <= '0;
      lockErrQ <= 1'b0;
      porShortQ <= 1'b0;
      cfgQ <= CFG_RST;
      strapOutQ <= CFG_RST;
    end
    else
    begin
      stateQ <= stateD;
      tickCntQ <= tickCntD;
      extCntQ <= extCntD;
      porCntQ <= porCntD;
      lockCntQ <= lockCntD;
      lockErrQ <= lockErrD;
      porShortQ <= porShortD;
      cfgQ <= cfgD;
      strapOutQ <= strapOutD;
    end
  end

  // R14 power-on reset never driven
  // R13 open-drain reset pins
  assign hardResetNOut = 1'b0;
  assign softResetNOut = 1'b0;
  assign hardResetNOe = (stateQ == ST_POR) || (stateQ == ST_DRIVE);
  assign softResetNOe = hardResetNOe || (stateQ == ST_RUN && softResetReq);
  // R9 strap pins released on the edge the sequencer asserts hard reset, two clocks after an outside assertion
  assign functionalEnable = (stateQ == ST_RUN);
  assign strapOe = functionalEnable && !hardLow;
  assign strapOut = strapOutQ;
  assign cfgCaptured = cfgQ;
  assign porTooShort = porShortQ;
  assign pllLockError = lockErrQ;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence sPorRelease;
    stateQ == ST_POR && !porLow ##1 stateQ == ST_DRIVE;
  endsequence
  sequence sDriveEnd;
    stateQ == ST_DRIVE && tickQ && tickCntQ == DRIVE_LAST && lockSync ##1 stateQ == ST_GAP;
  endsequence

  a_drive_min_len: assert property (stateQ == ST_GAP && $past(stateQ) == ST_DRIVE
    |-> $past(tickCntQ) == DRIVE_LAST) else $error("hard reset released early"); // R4
  a_drive_end_seq: assert property (stateQ == ST_DRIVE && tickQ && tickCntQ == DRIVE_LAST
    && lockSync && !porLow |-> ##1 stateQ == ST_GAP) else $error("drive did not end"); // R4
  a_negate_gap: assert property (stateQ == ST_RUN && $past(stateQ) == ST_GAP
    |-> $past(tickCntQ) == GAP_LAST && $past(tickQ)) else $error("gap too short"); // R5
  a_func_after_neg: assert property (sDriveEnd |-> !strapOe [*2])
    else $error("functional drive too soon"); // R10
  a_strap_release: assert property ($rose(hardResetNOe) |-> !strapOe)
    else $error("strap pins driven in hard reset"); // R9
  a_cfg_capture: assert property (sPorRelease |-> cfgQ == $past(strapSync))
    else $error("straps not captured at release"); // R8
  a_cfg_hold: assert property (stateQ != ST_POR && $past(stateQ) != ST_POR
    |-> $stable(cfgQ)) else $error("captured straps changed"); // R8
  a_open_drain: assert property (hardResetNOut == 1'b0 && softResetNOut == 1'b0)
    else $error("reset pin driven high"); // R13
  a_lock_timeout: assert property ($rose(lockErrQ) |-> $past(lockCntQ) == LOCK_LIMIT - 1'b1)
    else $error("lock error at wrong count"); // R12
  a_ext_restart: assert property (stateQ == ST_RUN && extCntQ == EXT_LIMIT && !porLow
    |=> stateQ == ST_DRIVE) else $error("outside hard reset ignored"); // R1
  a_host_divide: assert property (hostSync && $past(hostSync) && divSel && primRise
    && !divPhaseQ |=> !tickQ) else $error("divide setting ignored"); // R11
endmodule

// *** hw/ris_pkg.sv ***
// constants and carrier types for the reset initialization sequencer
package ris_pkg;
  // system clock rate
  localparam int CLOCK_MHZ = 100;
  // minimum assertion of an incoming hard or power-on reset, reference periods
  localparam int EXT_MIN_PERIODS = 32;
  // minimum assertion of the driven hard reset, sync periods
  localparam int DRIVE_MIN_PERIODS = 512;
  // minimum spacing between negations of the driven hard reset, sync periods
  localparam int NEGATE_GAP_PERIODS = 16;
  // strap setup before power-on release, reference periods
  localparam int STRAP_SETUP_PERIODS = 4;
  // least wait after hard reset negation before shared pins drive
  localparam int FUNC_WAIT_PERIODS = 1;
  // longest pll lock time, microseconds, and its cycle count
  localparam int PLL_LOCK_TIME_US = 100;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_TIME_US * CLOCK_MHZ;
  // counter widths
  localparam int TICK_W = 10;
  localparam int EXT_W = 6;
  localparam int LOCK_W = 14;
  // reset values of captured straps
  localparam logic [3:0] RESET_SOURCE_RST = 4'h0;
  localparam logic LOCAL_BUS_MUX_RST = 1'b0;
  localparam logic CLOCK_DIVIDE_RST = 1'b0;

  // power-on configuration strap set
  typedef struct packed {
    logic [3:0] resetSource;
    logic localBusMux;
    logic inputClockDivide;
  } ris_cfg_type;

  localparam ris_cfg_type CFG_RST = '{RESET_SOURCE_RST, LOCAL_BUS_MUX_RST, CLOCK_DIVIDE_RST};

  // sequencer states
  typedef enum logic [1:0] {
    ST_POR,
    ST_DRIVE,
    ST_GAP,
    ST_RUN
  } ris_state_type;
endpackage

// *** sim/ris_board_model.sv ***
// board side: reset supervisor, strap resistors, reference clocks
`timescale 1ns/1ps
module ris_board_model (
  // board controls
  input wire logic porAssert,
  input wire logic extPull,
  input wire ris_pkg::ris_cfg_type strapVal,
  // device pins
  input wire logic hardResetNOe,
  input wire logic strapOe,
  input wire ris_pkg::ris_cfg_type strapOut,
  output logic power_on_reset_n,
  output logic syncRefClock,
  output logic primary_input_clock,
  output logic hardResetNIn,
  output ris_pkg::ris_cfg_type strapIn
);
  import ris_pkg::*;
  // stable free-running clocks, 40 ns and 30 ns
  initial syncRefClock = 1'b0;
  initial primary_input_clock = 1'b0;
  always #20 syncRefClock = ~syncRefClock;
  always #15 primary_input_clock = ~primary_input_clock;
  assign power_on_reset_n = ~porAssert;
  // wire with pull-up, any party pulls low
  assign hardResetNIn = ~(hardResetNOe | extPull);
  // straps from resistors unless device drives
  assign strapIn = strapOe ? strapOut : strapVal;
endmodule

// *** sim/ris_sequencer_test.sv ***
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
module ris_sequencer_test;
  import ris_pkg::*;
  localparam int LockCycles = 200;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic porAssert = 1'b1;
  logic extPull = 1'b0;
  logic pllLocked = 1'b0;
  logic hardResetReq = 1'b0;
  logic softResetReq = 1'b0;
  logic hostMode = 1'b0;
  ris_cfg_type strapVal = 6'h2d;
  ris_cfg_type funcData = 6'h13;
  logic power_on_reset_n, hardResetNIn, hardResetNOut, hardResetNOe;
  logic softResetNOut, softResetNOe, primary_input_clock, syncRefClock;
  logic strapOe, functionalEnable, porTooShort, pllLockError, syncTick;
  ris_cfg_type strapIn, strapOut, cfgCaptured;
  int badCount = 0;
  int numChecks = 0;
  int cycles = 0;
  int tickCount = 0;
  int oeTicks = 0;
  int t0;

  ris_board_model board_u (.porAssert(porAssert), .extPull(extPull), .strapVal(strapVal),
    .hardResetNOe(hardResetNOe), .strapOe(strapOe), .strapOut(strapOut),
    .power_on_reset_n(power_on_reset_n), .syncRefClock(syncRefClock),
    .primary_input_clock(primary_input_clock), .hardResetNIn(hardResetNIn),
    .strapIn(strapIn));

  ris_sequencer #(.PllLockCycles(LockCycles)) dut_u (.clock(clock), .sys_rst(sys_rst),
    .power_on_reset_n(power_on_reset_n), .hardResetNIn(hardResetNIn),
    .hardResetNOut(hardResetNOut), .hardResetNOe(hardResetNOe),
    .softResetNIn(~softResetNOe), .softResetNOut(softResetNOut),
    .softResetNOe(softResetNOe), .primary_input_clock(primary_input_clock),
    .syncRefClock(syncRefClock), .hostMode(hostMode), .pllLocked(pllLocked),
    .strapIn(strapIn), .strapOut(strapOut), .strapOe(strapOe), .funcData(funcData),
    .hardResetReq(hardResetReq), .softResetReq(softResetReq),
    .cfgCaptured(cfgCaptured), .functionalEnable(functionalEnable),
    .porTooShort(porTooShort), .pllLockError(pllLockError), .syncTick(syncTick));

  // clock
  always #5 clock = ~clock;

  // verdict and end of run
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // cycle ceiling, sync tick tally, ticks seen while hard reset is driven
  always @(posedge clock)
  begin
    cycles++;
    if (syncTick === 1'b1)
      tickCount++;
    if (hardResetNOe !== 1'b1)
      oeTicks = 0;
    else if (syncTick === 1'b1)
      oeTicks++;
    if (cycles == 20000)
    begin
      badCount++;
      endOfTest();
    end
  end

  task automatic cmpBit(input logic got, input logic exp);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpCfg(input ris_cfg_type got, input ris_cfg_type exp);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask

  // one full driven reset up to functional drive; tally still holds the drive length
  task automatic driveCycle();
    while (hardResetNOe !== 1'b0)
      @(negedge clock);
    cmpBit(oeTicks >= DRIVE_MIN_PERIODS, 1'b1);
    t0 = tickCount;
    while (functionalEnable !== 1'b1)
      @(negedge clock);
    cmpBit(tickCount - t0 >= NEGATE_GAP_PERIODS, 1'b1);
    step(2);
    cmpBit(strapOe, 1'b1);
    cmpCfg(strapIn, funcData);
  endtask

  initial
  begin
    step(10);
    sys_rst = 1'b0;
    cmpBit(hardResetNOe, 1'b1);
    cmpBit(hardResetNOut, 1'b0);
    cmpBit(strapOe, 1'b0);
    step(10);
    porAssert = 1'b0;
    step(8);
    cmpBit(porTooShort, 1'b1);
    porAssert = 1'b1;
    step(200);
    porAssert = 1'b0;
    step(8);
    cmpBit(porTooShort, 1'b0);
    cmpCfg(cfgCaptured, 6'h2d);
    strapVal = 6'h12;
    step(LockCycles + 50);
    cmpBit(pllLockError, 1'b1);
    cmpBit(hardResetNOe, 1'b1);
    cmpCfg(cfgCaptured, 6'h2d);
    pllLocked = 1'b1;
    driveCycle();
    $display("test power-on done");
    softResetReq = 1'b1;
    step(2);
    cmpBit(softResetNOe, 1'b1);
    cmpBit(softResetNOut, 1'b0);
    softResetReq = 1'b0;
    step(2);
    cmpBit(softResetNOe, 1'b0);
    $display("test soft reset done");
    extPull = 1'b1;
    step(10);
    cmpBit(strapOe, 1'b0);
    step(70);
    extPull = 1'b0;
    step(20);
    cmpBit(functionalEnable, 1'b1);
    extPull = 1'b1;
    step(160);
    extPull = 1'b0;
    step(2);
    cmpBit(hardResetNOe, 1'b1);
    driveCycle();
    $display("test outside reset done");
    hardResetReq = 1'b1;
    step(1);
    hardResetReq = 1'b0;
    cmpBit(hardResetNOe, 1'b1);
    cmpBit(strapOe, 1'b0);
    driveCycle();
    cmpCfg(cfgCaptured, 6'h2d);
    $display("test driven reset done");
    // host mode power-on, straps settled long before release
    strapVal = 6'h35;
    hostMode = 1'b1;
    porAssert = 1'b1;
    step(20);
    porAssert = 1'b0;
    step(8);
    cmpBit(porTooShort, 1'b1);
    porAssert = 1'b1;
    step(120);
    porAssert = 1'b0;
    step(8);
    cmpBit(porTooShort, 1'b0);
    cmpCfg(cfgCaptured, 6'h35);
    cmpBit(pllLockError, 1'b0);
    // 6000 ns hold 200 primary periods, halved by the divide strap
    t0 = tickCount;
    step(600);
    cmpBit(tickCount - t0 >= 99 && tickCount - t0 <= 101, 1'b1);
    driveCycle();
    cmpCfg(cfgCaptured, 6'h35);
    $display("test host mode done");
    endOfTest();
  end
endmodule
